// *** include/arf_pkg.sv ***
// Register map, field positions and reset values of the conversion result block
package arf_pkg;
    // Word indices on the register bus
    localparam logic [2:0] ARF_IDX_RESULT_HIGH = 3'h0;
    localparam logic [2:0] ARF_IDX_RESULT_LOW = 3'h1;
    localparam logic [2:0] ARF_IDX_CONTROL = 3'h2;
    localparam logic [2:0] ARF_IDX_STATUS = 3'h3;
    // Control register fields
    localparam int ARF_CTRL_IN_PROGRESS_BIT = 0;
    localparam int ARF_CTRL_JUSTIFY_BIT = 7;
    // Status register fields
    localparam int ARF_STAT_COMPLETE_BIT = 0;
    // Justification encoding
    localparam logic ARF_JUSTIFY_LEFT = 1'b0;
    localparam logic ARF_JUSTIFY_RIGHT = 1'b1;
    // Reset values
    localparam logic [31:0] ARF_READDATA_RST = 32'h0000_0000;
    localparam logic ARF_WAIT_RST = 1'b1;
    localparam logic ARF_JUSTIFY_RST = 1'b0;
    // Widths
    localparam int ARF_VALUE_W = 10;
    localparam int ARF_REG_W = 8;
    localparam int ARF_ADDR_W = 3;
endpackage

// *** hw/arf_result_format.sv ***
// Conversion result registers with justification, start control and completion flag
`timescale 1ns/1ps
`default_nettype none
module arf_result_format
    import arf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [arf_pkg::ARF_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Converter core
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [arf_pkg::ARF_VALUE_W-1:0] conversion_value,
    // Status seen by the rest of the device
    output logic conversion_in_progress,
    output logic conversion_complete_flag,
    output logic result_justify_select
);
    import arf_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [31:0] readdata;
        logic wait_n_idle;
        logic start;
        logic busy;
        logic complete;
        logic justify;
    } arf_ctrl_t;

    // Result registers live apart: the only reset wired here is not a
    // power-on reset, and these must survive it with their contents.
    typedef struct packed {
        logic [ARF_REG_W-1:0] high;
        logic [ARF_REG_W-1:0] low;
    } arf_result_t;

    arf_ctrl_t ctrl_q;
    arf_ctrl_t ctrl_d;
    arf_result_t res_q;
    arf_result_t res_d;

    logic req;
    logic commit;
    logic wr_ok;
    logic [7:0] wbyte;

    assign req = avs_read | avs_write;
    // A write lands only at the edge where waitrequest is seen low
    assign commit = avs_write & ~ctrl_q.wait_n_idle;
    assign wr_ok = commit & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        ctrl_d = ctrl_q;
        res_d = res_q;
        ctrl_d.start = 1'b0;

        // Bus handshake: one wait cycle, then one acknowledge cycle
        if (req && ctrl_q.wait_n_idle) begin
            ctrl_d.wait_n_idle = 1'b0;
            ctrl_d.readdata = 32'h0000_0000;
            if (avs_address == ARF_IDX_RESULT_HIGH) begin
                ctrl_d.readdata[ARF_REG_W-1:0] = res_q.high;
            end else if (avs_address == ARF_IDX_RESULT_LOW) begin
                ctrl_d.readdata[ARF_REG_W-1:0] = res_q.low;
            end else if (avs_address == ARF_IDX_CONTROL) begin
                ctrl_d.readdata[ARF_CTRL_IN_PROGRESS_BIT] = ctrl_q.busy;
                ctrl_d.readdata[ARF_CTRL_JUSTIFY_BIT] = ctrl_q.justify;
            end else if (avs_address == ARF_IDX_STATUS) begin
                ctrl_d.readdata[ARF_STAT_COMPLETE_BIT] = ctrl_q.complete;
            end
        end else begin
            ctrl_d.wait_n_idle = 1'b1;
        end

        // Software writes
        if (wr_ok) begin
            if (avs_address == ARF_IDX_RESULT_HIGH) begin
                res_d.high = wbyte;
            end else if (avs_address == ARF_IDX_RESULT_LOW) begin
                res_d.low = wbyte;
            end else if (avs_address == ARF_IDX_CONTROL) begin
                ctrl_d.justify = wbyte[ARF_CTRL_JUSTIFY_BIT];
                // Acquisition delay before this write is software's duty
                if (wbyte[ARF_CTRL_IN_PROGRESS_BIT] && !ctrl_q.busy) begin
                    ctrl_d.busy = 1'b1;
                    ctrl_d.start = 1'b1;
                end
            end else if (avs_address == ARF_IDX_STATUS) begin
                if (wbyte[ARF_STAT_COMPLETE_BIT]) begin
                    ctrl_d.complete = 1'b0;
                end
            end
        end

        // Completion overrides a same-cycle software write to the result registers or the status flag,
        // so a finishing conversion is never lost to a racing store.
        if (conv_done && ctrl_q.busy) begin
            ctrl_d.busy = 1'b0;
            ctrl_d.complete = 1'b1;
            if (ctrl_q.justify == ARF_JUSTIFY_RIGHT) begin
                res_d.high = {6'h00, conversion_value[9:8]};
                res_d.low = conversion_value[7:0];
            end else begin
                res_d.high = conversion_value[9:2];
                res_d.low = {conversion_value[1:0], 6'h00};
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '{readdata: ARF_READDATA_RST, wait_n_idle: ARF_WAIT_RST,
                        start: 1'b0, busy: 1'b0, complete: 1'b0,
                        justify: ARF_JUSTIFY_RST};
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // No reset: contents persist across device resets
    always_ff @(posedge clk) begin
        res_q <= res_d;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign avs_readdata = ctrl_q.readdata;
    assign avs_waitrequest = ctrl_q.wait_n_idle;
    assign conv_start = ctrl_q.start;
    assign conversion_in_progress = ctrl_q.busy;
    assign conversion_complete_flag = ctrl_q.complete;
    assign result_justify_select = ctrl_q.justify;
endmodule
`default_nettype wire

// *** sim/arf_result_format_properties.sv ***
// Port-level checker for the conversion result block
`timescale 1ns/1ps
`default_nettype none
module arf_result_format_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Converter side
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic conversion_in_progress,
    input wire logic conversion_complete_flag
);
    // ====
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not acknowledged");
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge longer than one cycle");
    a_read_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_done_clears_busy: assert property (conv_done && conversion_in_progress |=> !conversion_in_progress)
        else $error("busy not cleared at completion");
    a_done_sets_flag: assert property (conv_done && conversion_in_progress |=> conversion_complete_flag)
        else $error("flag not set at completion");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    a_start_busy: assert property (conv_start |-> conversion_in_progress)
        else $error("start without busy");
    a_busy_rise_start: assert property ($rose(conversion_in_progress) |-> conv_start)
        else $error("busy rose without start");
    cover property (conv_start);
    cover property (conv_done && conversion_in_progress);
    cover property (avs_read && !avs_waitrequest);
endmodule
bind arf_result_format arf_result_format_chk u_chk (.*);
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the conversion result block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import arf_pkg::*;
    // ====
    // Stimulus and observed signals
    logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, conv_done = 0;
    logic [2:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hf;
    logic [9:0] conversion_value = 0, v;
    logic avs_waitrequest, conv_start, conversion_in_progress;
    logic conversion_complete_flag, result_justify_select;
    logic [7:0] q[$];
    int miscompares = 0, comparisons = 0, cyc = 0;
    arf_result_format dut (.*);
    initial begin
        forever #10 clk = ~clk;
    end
    // Read results are compared against the oldest note in order
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            end_of_test;
        end
        if (avs_read && !avs_waitrequest) begin
            comparisons++;
            if (avs_readdata !== {24'h0, q[0]}) begin
                miscompares++;
                $display("MISMATCH %0t read %h", $time, avs_readdata);
            end
            void'(q.pop_front());
        end
    end
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        q.push_back(e);
        bus(0, a, 8'h0);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h50d9));
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int j = 0; j < 2; j++) begin
            v = 10'($urandom);
            repeat (4) @(posedge clk);
            bus(1, ARF_IDX_CONTROL, {j[0], 6'h0, 1'b1});
            conv_done <= 1;
            conversion_value <= v;
            @(posedge clk);
            conv_done <= 0;
            @(posedge clk);
            rd(ARF_IDX_STATUS, 8'h01);
            rd(ARF_IDX_RESULT_HIGH, j ? {6'h0, v[9:8]} : v[9:2]);
            rd(ARF_IDX_RESULT_LOW, j ? v[7:0] : {v[1:0], 6'h0});
            rd(ARF_IDX_CONTROL, {j[0], 7'h0});
            comparisons++;
            if (result_justify_select !== j[0]) begin
                miscompares++;
                $display("MISMATCH %0t justify select", $time);
            end
            bus(1, ARF_IDX_STATUS, 8'h01);
            rd(ARF_IDX_STATUS, 8'h00);
        end
        // Refused requests must leave state alone
        avs_byteenable <= 4'h0;
        bus(1, ARF_IDX_RESULT_LOW, 8'h5a);
        avs_byteenable <= 4'hf;
        rd(ARF_IDX_RESULT_LOW, v[7:0]);
        conv_done <= 1;
        conversion_value <= ~v;
        @(posedge clk);
        conv_done <= 0;
        @(posedge clk);
        rd(ARF_IDX_RESULT_HIGH, {6'h0, v[9:8]});
        rd(ARF_IDX_STATUS, 8'h00);
        // A second start while busy is dropped, justify still lands
        bus(1, ARF_IDX_CONTROL, 8'h81);
        bus(1, ARF_IDX_CONTROL, 8'h01);
        rd(ARF_IDX_CONTROL, 8'h01);
        conv_done <= 1;
        conversion_value <= v;
        @(posedge clk);
        conv_done <= 0;
        @(posedge clk);
        rd(ARF_IDX_CONTROL, 8'h00);
        rd(ARF_IDX_RESULT_LOW, {v[1:0], 6'h0});
        bus(1, ARF_IDX_STATUS, 8'h01);
        // Results must survive a non-power reset
        bus(1, ARF_IDX_RESULT_HIGH, v[7:0]);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(ARF_IDX_RESULT_HIGH, v[7:0]);
        rd(3'h5, 8'h00);
        end_of_test;
    end
endmodule
`default_nettype wire
